// ==== hw/sal_ctrl.sv ====
// Aux output gating, lock status, restart and loss-of-lock control with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "sal_regs.svh"

module sal_ctrl #(
  parameter int ADDR_W = 20
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire sal_pkg::sal_rx_in_type rx_in,
  output sal_pkg::sal_rx_out_type rx_out,
  input wire logic spdif_i2s_sel,
  input wire logic aux_stream_in,
  output logic aux_stream_out,
  output logic aux_out_en,
  output logic irq
);
  import sal_pkg::*;

  // Write channel holding registers
  logic aw_held_reg;
  logic aw_held_next;
  logic [15:0] aw_idx_reg;
  logic [15:0] aw_idx_next;
  logic w_held_reg;
  logic w_held_next;
  logic [15:0] w_data_reg;
  logic [15:0] w_data_next;
  logic [1:0] w_strb_reg;
  logic [1:0] w_strb_next;
  logic bvalid_reg;
  logic bvalid_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;

  // Read channel registers
  logic rvalid_reg;
  logic rvalid_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;

  // Control and status state
  logic [1:0] mode_reg;
  logic [1:0] mode_next;
  logic hot_reg;
  logic hot_next;
  logic behav_reg;
  logic behav_next;
  logic lock_reg;
  logic aux_en_reg;
  logic aux_en_next;
  logic [`SAL_IRQ_W-1:0] irq_sts_reg;
  logic [`SAL_IRQ_W-1:0] irq_sts_next;
  logic [`SAL_IRQ_W-1:0] irq_mask_reg;
  logic [`SAL_IRQ_W-1:0] irq_mask_next;
  logic [`SAL_IRQ_W-1:0] irq_event;
  sal_rx_out_type rx_out_reg;
  sal_rx_out_type rx_out_next;

  // Address decode: the word index is the byte address shifted by two
  // Bits above the 16-bit index must be clear, or far addresses would alias registers
  localparam logic [15:0] IDX_NONE = 16'hffff;
  wire [ADDR_W-3:0] ar_word = s_axi_araddr[ADDR_W-1:2];
  wire [ADDR_W-3:0] aw_word = s_axi_awaddr[ADDR_W-1:2];
  wire ar_in_range = ((ar_word >> 16) == '0);
  wire aw_in_range = ((aw_word >> 16) == '0);
  wire [15:0] ar_idx = ar_in_range ? 16'(ar_word) : IDX_NONE;
  wire [15:0] aw_idx_in = aw_in_range ? 16'(aw_word) : IDX_NONE;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;

  wire wr_mode = wr_fire && (aw_idx_reg == `SAL_IDX_MODE);
  wire wr_lock = wr_fire && (aw_idx_reg == `SAL_IDX_LOCK);
  wire wr_hot = wr_fire && (aw_idx_reg == `SAL_IDX_HOT);
  wire wr_auxen = wr_fire && (aw_idx_reg == `SAL_IDX_AUXEN);
  wire wr_behav = wr_fire && (aw_idx_reg == `SAL_IDX_BEHAV);
  wire wr_sts = wr_fire && (aw_idx_reg == `SAL_IDX_IRQ_STS);
  wire wr_mask = wr_fire && (aw_idx_reg == `SAL_IDX_IRQ_MASK);
  wire wr_hit = wr_mode || wr_lock || wr_hot || wr_auxen || wr_behav || wr_sts || wr_mask;

  // Only the low byte lane carries live bits
  wire lane0 = w_strb_reg[0];
  wire [7:0] wbyte = w_data_reg[7:0];

  wire rd_mode = (ar_idx == `SAL_IDX_MODE);
  wire rd_lock = (ar_idx == `SAL_IDX_LOCK);
  wire rd_hot = (ar_idx == `SAL_IDX_HOT);
  wire rd_auxen = (ar_idx == `SAL_IDX_AUXEN);
  wire rd_behav = (ar_idx == `SAL_IDX_BEHAV);
  wire rd_sts = (ar_idx == `SAL_IDX_IRQ_STS);
  wire rd_mask = (ar_idx == `SAL_IDX_IRQ_MASK);
  wire rd_hit = rd_mode || rd_lock || rd_hot || rd_auxen || rd_behav || rd_sts || rd_mask;

  // Read mux; upper bits stay zero
  wire [31:0] rd_word =
    rd_mode ? {30'h0, mode_reg} :
    rd_lock ? {31'h0, lock_reg} :
    rd_hot ? {31'h0, hot_reg} :
    rd_auxen ? {31'h0, aux_en_reg} :
    rd_behav ? {31'h0, behav_reg} :
    rd_sts ? {29'h0, irq_sts_reg} :
    rd_mask ? {29'h0, irq_mask_reg} :
    32'h0000_0000;

  // Lock edges; lock input is taken as synchronous to mclk
  wire lock_fall = lock_reg && !rx_in.lock;
  wire lock_rise = !lock_reg && rx_in.lock;

  // Mode decode for the aux enable
  wire mode_gate_on = hot_next && rx_in.lock;
  wire aux_en_calc =
    (mode_reg == `SAL_MODE_ON) ? 1'b1 :
    (mode_reg == `SAL_MODE_GATED) ? mode_gate_on :
    1'b0;

  // Event sources of the sticky status bits
  assign irq_event[`SAL_IRQ_LOST] = lock_fall;
  assign irq_event[`SAL_IRQ_GAINED] = lock_rise;
  assign irq_event[`SAL_IRQ_AUXOFF] = aux_en_reg && !aux_en_next;

  // Bus handshake outputs
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // Pin gating only acts while the S/PDIF-to-I2S function drives the pins
  assign aux_out_en = aux_en_reg && spdif_i2s_sel;
  assign aux_stream_out = aux_stream_in && aux_out_en;
  assign rx_out = rx_out_reg;
  assign irq = |(irq_sts_reg & irq_mask_reg);

  // Write address and data are latched independently, in either order
  always_comb begin
    aw_held_next = aw_held_reg;
    aw_idx_next = aw_idx_reg;
    w_held_next = w_held_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (aw_take) begin
      aw_held_next = 1'b1;
      aw_idx_next = aw_idx_in;
    end
    if (w_take) begin
      w_held_next = 1'b1;
      w_data_next = s_axi_wdata[15:0];
      w_strb_next = s_axi_wstrb[1:0];
    end
    if (wr_fire) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wr_hit ? `SAL_RESP_OKAY : `SAL_RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
  end

  // Read answer registered one cycle after the address is taken
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (ar_take) begin
      rvalid_next = 1'b1;
      rdata_next = rd_word;
      rresp_next = rd_hit ? `SAL_RESP_OKAY : `SAL_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  // Control register updates
  always_comb begin
    mode_next = mode_reg;
    behav_next = behav_reg;
    irq_mask_next = irq_mask_reg;
    hot_next = hot_reg;
    if (wr_mode && lane0) begin
      mode_next = wbyte[1:0];
    end
    if (wr_behav && lane0) begin
      behav_next = wbyte[0];
    end
    if (wr_mask && lane0) begin
      irq_mask_next = wbyte[`SAL_IRQ_W-1:0];
    end
    if (wr_hot && lane0) begin
      hot_next = wbyte[0];
    end
    // Hardware clear beats a software set: no restart without lock
    if (!rx_in.lock) begin
      hot_next = 1'b0;
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_comb begin
    irq_sts_next = irq_sts_reg;
    if (wr_sts && lane0) begin
      irq_sts_next = irq_sts_reg & ~wbyte[`SAL_IRQ_W-1:0];
    end
    irq_sts_next = irq_sts_next | irq_event;
  end

  // One register feeds status and pins; the pins are also gated by spdif_i2s_sel, which the status read does not show
  assign aux_en_next = aux_en_calc;

  // Receiver output shaping by loss-of-lock behaviour
  always_comb begin
    rx_out_next = '0;
    if (behav_reg) begin
      rx_out_next.frame_sync = rx_in.frame_sync;
      rx_out_next.data = rx_in.lock ? rx_in.data : 24'h00_0000;
      rx_out_next.src_mute = 1'b0;
    end else begin
      rx_out_next.frame_sync = rx_in.frame_sync && rx_in.lock;
      rx_out_next.data = rx_in.lock ? rx_in.data : 24'h00_0000;
      rx_out_next.src_mute = !rx_in.lock;
    end
  end

  // Write channel state
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      aw_held_reg <= 1'b0;
      aw_idx_reg <= 16'h0000;
      w_held_reg <= 1'b0;
      w_data_reg <= 16'h0000;
      w_strb_reg <= 2'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `SAL_RESP_OKAY;
    end else begin
      aw_held_reg <= aw_held_next;
      aw_idx_reg <= aw_idx_next;
      w_held_reg <= w_held_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
    end
  end

  // Read answer state; rdata freezes at the take edge and stands until rready
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `SAL_RESP_OKAY;
    end else begin
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // Software control bits and sticky status
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mode_reg <= `SAL_RST_MODE;
      hot_reg <= `SAL_RST_HOT;
      behav_reg <= `SAL_RST_BEHAV;
      irq_mask_reg <= `SAL_RST_IRQ;
      irq_sts_reg <= `SAL_RST_IRQ;
    end else begin
      mode_reg <= mode_next;
      hot_reg <= hot_next;
      behav_reg <= behav_next;
      irq_mask_reg <= irq_mask_next;
      irq_sts_reg <= irq_sts_next;
    end
  end

  // Lock flag and aux enable state, readable by software
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      lock_reg <= 1'b0;
      aux_en_reg <= 1'b0;
    end else begin
      lock_reg <= rx_in.lock;
      aux_en_reg <= aux_en_next;
    end
  end

  // Registered receiver outputs, one cycle behind rx_in
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rx_out_reg <= '0;
    end else begin
      rx_out_reg <= rx_out_next;
    end
  end

endmodule : sal_ctrl

`default_nettype wire

// ==== common/sal_regs.svh ====
// Register indices, field positions and reset values of the aux output lock control
`ifndef SAL_REGS_SVH
`define SAL_REGS_SVH

`define SAL_IDX_MODE 16'hE0C8
`define SAL_IDX_LOCK 16'hE0C9
`define SAL_IDX_HOT 16'hE0CA
`define SAL_IDX_AUXEN 16'hE0CB
`define SAL_IDX_BEHAV 16'hE0CC
`define SAL_IDX_IRQ_STS 16'hE0CD
`define SAL_IDX_IRQ_MASK 16'hE0CE

`define SAL_MODE_OFF 2'h0
`define SAL_MODE_ON 2'h1
`define SAL_MODE_GATED 2'h2

`define SAL_RST_MODE 2'h1
`define SAL_RST_HOT 1'h0
`define SAL_RST_BEHAV 1'h0
`define SAL_RST_IRQ 3'h0

`define SAL_IRQ_LOST 0
`define SAL_IRQ_GAINED 1
`define SAL_IRQ_AUXOFF 2
`define SAL_IRQ_W 3

`define SAL_RESP_OKAY 2'h0
`define SAL_RESP_SLVERR 2'h2

`endif

// ==== common/sal_pkg.sv ====
// Types shared by the aux output lock control
`default_nettype none
package sal_pkg;

  typedef struct packed {
    logic lock;
    logic frame_sync;
    logic [23:0] data;
  } sal_rx_in_type;

  typedef struct packed {
    logic frame_sync;
    logic [23:0] data;
    logic src_mute;
  } sal_rx_out_type;

endpackage : sal_pkg
`default_nettype wire

// ==== test/sal_src_model.sv ====
// Behavioural digital audio stream source feeding the receiver side
`timescale 1ns/1ps
`default_nettype none

module sal_src_model (
  input wire logic mclk,
  input wire logic lock_cmd,
  output sal_pkg::sal_rx_in_type rx_in
);
  import sal_pkg::*;
  logic [7:0] cnt = 8'h00;
  initial rx_in = '0;
  // Unlocked data is scrambled every cycle so no stale word can pass for zero
  always @(posedge mclk) begin
    cnt <= cnt + 8'h01;
    rx_in.lock <= lock_cmd;
    rx_in.frame_sync <= (cnt[1:0] == 2'h0);
    rx_in.data <= lock_cmd ? {16'h0010, cnt} : ~rx_in.data;
  end
endmodule : sal_src_model

`default_nettype wire

// ==== test/sal_ctrl_chk.sv ====
// Assertion checker bound to the aux output lock control
`timescale 1ns/1ps
`default_nettype none

module sal_ctrl_chk (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire sal_pkg::sal_rx_in_type rx_in,
  input wire sal_pkg::sal_rx_out_type rx_out,
  input wire logic spdif_i2s_sel,
  input wire logic aux_out_en
);
  import sal_pkg::*;
  // Two edges of delay: the first edge after release still shows reset values of rx_out
  logic up0;
  logic up;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      up0 <= 1'b0;
      up <= 1'b0;
    end else begin
      up0 <= 1'b1;
      up <= up0;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn || !up);
  a_sel_gate: assert property (!spdif_i2s_sel |-> !aux_out_en)
    else $error("aux enable without function select");
  a_mute_nosync: assert property (rx_out.src_mute |-> !rx_out.frame_sync)
    else $error("frame sync while muted");
  a_lock_nomute: assert property ($past(rx_in.lock) |-> !rx_out.src_mute)
    else $error("muted while locked");
  a_unlock_zero: assert property (!$past(rx_in.lock) |-> rx_out.data == 24'h00_0000)
    else $error("data not zero without lock");
  a_lock_data: assert property ($past(rx_in.lock) |-> rx_out.data == $past(rx_in.data))
    else $error("locked data not passed");
  a_lock_sync: assert property ($past(rx_in.lock && rx_in.frame_sync) |-> rx_out.frame_sync)
    else $error("frame sync lost while locked");
  a_drop_mute: assert property ($past(rx_in.frame_sync) && !rx_out.frame_sync |-> rx_out.src_mute)
    else $error("frame sync dropped without mute");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  c_lock_lost: cover property ($fell(rx_in.lock));
  c_aux_on: cover property ($rose(aux_out_en));
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : sal_ctrl_chk

bind sal_ctrl sal_ctrl_chk u_chk (.mclk, .resetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .rx_in, .rx_out,
  .spdif_i2s_sel, .aux_out_en);

`default_nettype wire

// ==== test/spdif_aux_output_lock_control_test.sv ====
// Self-checking bench of the aux output lock control
`timescale 1ns/1ps
`default_nettype none
`include "sal_regs.svh"

module spdif_aux_output_lock_control_test;
  import sal_pkg::*;
  logic mclk = 0, resetn = 0, sel = 1, ain = 0, lock_cmd = 1;
  logic [19:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic aux_stream_out, aux_out_en, irq;
  sal_rx_in_type rx_in;
  sal_rx_out_type rx_out;
  int n_fail = 0, num_checks = 0, cyc = 0;
  always #5 mclk = ~mclk;
  sal_src_model src (.mclk, .lock_cmd, .rx_in);
  sal_ctrl uut (.mclk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .rx_in, .rx_out, .spdif_i2s_sel(sel), .aux_stream_in(ain), .aux_stream_out,
    .aux_out_en, .irq);
  // Well above the roughly 200 cycles the scenarios need
  always @(posedge mclk) begin
    ain <= ~ain;
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      results();
    end
  end
  task results;
    if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
    @(posedge mclk);
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bready && s_axi_bvalid) begin
        chk("bresp", 32'(s_axi_bresp), 32'(er));
        s_axi_bready <= 0;
      end
    end while (s_axi_bready);
  endtask : wr
  task rd(input logic [15:0] idx, input logic [31:0] e, input logic [1:0] er);
    @(posedge mclk);
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rready && s_axi_rvalid) begin
        chk("rdata", s_axi_rdata, e);
        chk("rresp", 32'(s_axi_rresp), 32'(er));
        s_axi_rready <= 0;
      end
    end while (s_axi_rready);
  endtask : rd
  task t_reset;
    rd(`SAL_IDX_MODE, 32'h1, 2'h0);
    rd(`SAL_IDX_HOT, 32'h0, 2'h0);
    rd(`SAL_IDX_AUXEN, 32'h1, 2'h0);
    rd(`SAL_IDX_BEHAV, 32'h0, 2'h0);
    wr(`SAL_IDX_LOCK, 32'h0, 2'h0);
    rd(`SAL_IDX_LOCK, 32'h1, 2'h0);
    wr(`SAL_IDX_BEHAV, 32'hffff_ffff, 2'h0);
    rd(`SAL_IDX_BEHAV, 32'h1, 2'h0);
    s_axi_wstrb <= 4'he;
    wr(`SAL_IDX_BEHAV, 32'h0, 2'h0);
    s_axi_wstrb <= 4'hf;
    rd(`SAL_IDX_BEHAV, 32'h1, 2'h0);
    wr(16'he0d0, 32'h1, `SAL_RESP_SLVERR);
    rd(16'he0d0, 32'h0, `SAL_RESP_SLVERR);
  endtask : t_reset
  task t_modes;
    for (int i = 0; i < 4; i++) begin
      wr(`SAL_IDX_MODE, 32'(i), 2'h0);
      rd(`SAL_IDX_AUXEN, 32'(i == 1), 2'h0);
      chk("aux_out_en", 32'(aux_out_en), 32'(i == 1));
    end
    wr(`SAL_IDX_MODE, 32'(`SAL_MODE_GATED), 2'h0);
    wr(`SAL_IDX_HOT, 32'h1, 2'h0);
    chk("aux_out_en", 32'(aux_out_en), 32'h1);
    chk("aux_stream_out", 32'(aux_stream_out), 32'(ain));
    @(posedge mclk);
    chk("aux_stream_out", 32'(aux_stream_out), 32'(ain));
    sel <= 0;
    repeat (2) @(posedge mclk);
    chk("aux_stream_out", 32'(aux_stream_out), 32'h0);
    chk("aux_out_en", 32'(aux_out_en), 32'h0);
    rd(`SAL_IDX_AUXEN, 32'h1, 2'h0);
    sel <= 1;
    lock_cmd <= 0;
    repeat (4) @(posedge mclk);
    chk("aux_out_en", 32'(aux_out_en), 32'h0);
    rd(`SAL_IDX_HOT, 32'h0, 2'h0);
    rd(`SAL_IDX_LOCK, 32'h0, 2'h0);
    wr(`SAL_IDX_HOT, 32'h1, 2'h0);
    rd(`SAL_IDX_HOT, 32'h0, 2'h0);
    lock_cmd <= 1;
    repeat (4) @(posedge mclk);
    chk("aux_out_en", 32'(aux_out_en), 32'h0);
    wr(`SAL_IDX_HOT, 32'h1, 2'h0);
    chk("aux_out_en", 32'(aux_out_en), 32'h1);
  endtask : t_modes
  task t_behav;
    logic fs, mu;
    logic [23:0] dt;
    for (int b = 0; b < 2; b++) begin
      wr(`SAL_IDX_BEHAV, 32'(b), 2'h0);
      lock_cmd <= 0;
      repeat (4) @(posedge mclk);
      fs = 0;
      mu = 1;
      dt = '0;
      repeat (8) begin
        @(posedge mclk);
        fs |= rx_out.frame_sync;
        mu &= rx_out.src_mute;
        dt |= rx_out.data;
      end
      chk("frame_sync", 32'(fs), 32'(b));
      chk("src_mute", 32'(mu), 32'(b == 0));
      chk("rx_data", 32'(dt), 32'h0);
      lock_cmd <= 1;
      repeat (4) @(posedge mclk);
      fs = 0;
      repeat (8) begin
        @(posedge mclk);
        fs |= rx_out.frame_sync;
      end
      chk("frame_sync", 32'(fs), 32'h1);
    end
  endtask : t_behav
  task t_irq;
    wr(`SAL_IDX_MODE, 32'(`SAL_MODE_ON), 2'h0);
    wr(`SAL_IDX_IRQ_STS, 32'h7, 2'h0);
    wr(`SAL_IDX_IRQ_MASK, 32'h7, 2'h0);
    chk("irq", 32'(irq), 32'h0);
    lock_cmd <= 0;
    repeat (4) @(posedge mclk);
    rd(`SAL_IDX_IRQ_STS, 32'h1, 2'h0);
    chk("irq", 32'(irq), 32'h1);
    wr(`SAL_IDX_IRQ_MASK, 32'h6, 2'h0);
    chk("irq", 32'(irq), 32'h0);
    lock_cmd <= 1;
    repeat (4) @(posedge mclk);
    rd(`SAL_IDX_IRQ_STS, 32'h3, 2'h0);
    chk("irq", 32'(irq), 32'h1);
    wr(`SAL_IDX_IRQ_STS, 32'h3, 2'h0);
    chk("irq", 32'(irq), 32'h0);
    wr(`SAL_IDX_MODE, 32'(`SAL_MODE_OFF), 2'h0);
    rd(`SAL_IDX_IRQ_STS, 32'h4, 2'h0);
    chk("irq", 32'(irq), 32'h1);
  endtask : t_irq
  initial begin
    repeat (5) @(posedge mclk);
    resetn <= 1;
    t_reset();
    t_modes();
    t_behav();
    t_irq();
    results();
  end
endmodule : spdif_aux_output_lock_control_test

`default_nettype wire
